// [logic/power_mode_pkg.sv]
/*
  Constants for the power mode and wake-up control block: special function
  register addresses and pages, field positions, reset values, flag indices,
  mode states and timing figures.
  Assumes a single 100 MHz system clock that keeps running for this block.
*/
package power_mode_pkg;

  // Special function register addresses and pages.
  localparam logic [7:0] ADDR_POWER_CONTROL     = 8'h87;
  localparam logic [7:0] ADDR_POWER_CONFIG_WAKE = 8'hB5;
  localparam logic [7:0] ADDR_WAKE_FLAG_EXTRA   = 8'hCE;
  localparam logic [7:0] ADDR_MODE_OPTIONS      = 8'hCE;
  localparam logic [3:0] PAGE_PMU               = 4'h0;
  localparam logic [3:0] PAGE_MODE              = 4'hF;

  // Configuration register fields.
  localparam int CFG_SLEEP_BIT   = 7;
  localparam int CFG_SUSPEND_BIT = 6;
  localparam int CFG_CLEAR_BIT   = 5;
  localparam int CFG_RSTWAKE_BIT = 4;

  // Mode option register fields.
  localparam int MODE_RTC_OE_BIT  = 7;
  localparam int MODE_WAKE_OE_BIT = 6;
  localparam int MODE_SUPPLY_MONITOR_DISABLE_BIT  = 5;

  // Power control register fields.
  localparam int POWER_CONTROL_GF_MSB    = 7;
  localparam int POWER_CONTROL_GF_LSB    = 2;
  localparam int POWER_CONTROL_STOP_BIT  = 1;
  localparam int POWER_CONTROL_IDLE_BIT  = 0;
  localparam int GF_WIDTH       = 6;

  // Wake-up flag indices; the low five match configuration register bits.
  localparam int WAKE_COUNT     = 6;
  localparam int FLAG_COMP      = 0;
  localparam int FLAG_PORT      = 1;
  localparam int FLAG_ALARM     = 2;
  localparam int FLAG_OSCFAIL   = 3;
  localparam int FLAG_RSTPIN    = 4;
  localparam int FLAG_CAPSENSE  = 5;
  localparam int CFG_EN_WIDTH   = 4;

  // Reset values.
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [WAKE_COUNT-1:0] FLAGS_RESET = 6'h00;

  // Timing: flags read zero for two clocks after a suspend wake.
  localparam int CLK_PERIOD_NS      = 10;
  localparam int FLAG_HOLD_CYCLES   = 2;
  localparam int WAKE_LOW_NS        = 100;
  localparam int WAKE_LOW_CYCLES    = (WAKE_LOW_NS / CLK_PERIOD_NS < 1) ? 1
                                      : WAKE_LOW_NS / CLK_PERIOD_NS;
  localparam int COUNT_WIDTH        = 4;

  // Power states, Gray coded along active, idle, stop, suspend, sleep, wake.
  typedef enum logic [2:0] {
    ST_ACTIVE  = 3'b000,
    ST_IDLE    = 3'b001,
    ST_STOP    = 3'b011,
    ST_SUSPEND = 3'b010,
    ST_SLEEP   = 3'b110,
    ST_WAKE    = 3'b111
  } power_state_e;

endpackage

// [logic/wake_event_sync.sv]
/*
  Synchroniser bank for the asynchronous wake-up event lines.
  Each line passes two flip-flops, then a third stage gives a one-cycle
  pulse on the rising edge. Inputs come from other clock domains.
*/
`timescale 1ns/1ps
module wake_event_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             reset,
  // Asynchronous levels in, synchronous edge pulses and levels out.
  input  wire logic [WIDTH-1:0] eventAsync,
  output logic      [WIDTH-1:0] eventPulse,
  output logic      [WIDTH-1:0] eventLevel
);

  // One synchroniser and edge detector per line.
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_line
      logic meta_reg;
      logic sync_reg;
      logic last_reg;
      always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          last_reg <= 1'b0;
        end else begin
          meta_reg <= eventAsync[i];
          sync_reg <= meta_reg;
          last_reg <= sync_reg;
        end
      end
      assign eventPulse[i] = sync_reg & ~last_reg;
      assign eventLevel[i] = sync_reg;
    end
  endgenerate

endmodule

// [logic/power_mode_wakeup_control.sv]
/*
  Power mode and wake-up control: special function registers for sleep,
  suspend, stop and idle selection, wake-up enables and flags, mode options
  and general purpose flags, plus the power state sequencer.
  Assumes the register port runs on clk, which stays alive in all modes;
  the oscillators, regulator and wake-up peripherals are outside.
*/
// Functional notes
// - Writing sleep bit enters sleep state
// - Writing suspend bit enters suspend state
// - Clear bit clears every wake-up flag
// - Reset pin glitch flag, read only
// - Bit 2 enables alarm wake, reads flag
// - Bit 1 enables port match wake, reads flag
// - Bit 0 enables comparator wake, reads flag
// - Extra flag register bit 0 capacitive sense
// - Set flags block sleep, suspend, oscillator off
// - Flags read zero two clocks after suspend
// - Mode bit 7 enables buffered clock output
// - Mode bit 6 enables wake-request output
// - Mode bit 5 disables supply monitor
// - Mode bits 4:0 read zero
// - Control bits 7:2 general purpose storage
// - Control bit 1 enters stop mode
// - Control bit 0 enters idle mode
// - Leaving sleep drives wake request low
// - Reset with monitor off forces full reset
// - Stop ends only through reset
// - Suspend gates clock until enabled wake
`timescale 1ns/1ps
module power_mode_wakeup_control (
  // Clock and reset.
  input  wire logic                                  clk,
  input  wire logic                                  reset,
  // Special function register port.
  input  wire logic                                  sfrWrite,
  input  wire logic                                  sfrRead,
  input  wire logic [7:0]                            sfrAddr,
  input  wire logic [3:0]                            sfrPage,
  input  wire logic [7:0]                            sfrWdata,
  output logic      [7:0]                            sfrRdata,
  // Asynchronous wake-up event lines and the reset source.
  input  wire logic                                  rtcOscFail,
  input  wire logic                                  rtcAlarm,
  input  wire logic                                  portMatch,
  input  wire logic                                  comparatorRise,
  input  wire logic                                  capSenseEvent,
  input  wire logic                                  resetPinGlitch,
  input  wire logic                                  resetSourceActive,
  // Same-domain request from the interrupt controller.
  input  wire logic                                  interruptPending,
  // Power control outputs.
  output power_mode_pkg::power_state_e               powerState,
  output logic                                       cpuHalt,
  output logic                                       precisionOscStop,
  output logic                                       sysClockGate,
  output logic                                       regulatorOff,
  output logic                                       lowPowerOscKeepOn,
  output logic                                       rtcPinEnable,
  output logic                                       wakePinEnable,
  output logic                                       wakeRequestN,
  output logic                                       supplyMonitorDisable,
  output logic                                       fullPorRequest
);
  import power_mode_pkg::*;

  // Synchronised event pulses and the reset source level.
  logic [WAKE_COUNT-1:0] evtPulse;
  logic                  rstSrcLevel;

  wake_event_sync #(.WIDTH(WAKE_COUNT)) u_evt_sync (
    .clk        (clk),
    .reset      (reset),
    .eventAsync ({capSenseEvent, resetPinGlitch, rtcOscFail, rtcAlarm,
                  portMatch, comparatorRise}),
    .eventPulse (evtPulse),
    .eventLevel ()
  );

  wake_event_sync #(.WIDTH(1)) u_rst_sync (
    .clk        (clk),
    .reset      (reset),
    .eventAsync (resetSourceActive),
    .eventPulse (),
    .eventLevel (rstSrcLevel)
  );

  // Register state and next values.
  power_state_e                 state_reg, state_next;
  logic [WAKE_COUNT-1:0]        flags_reg, flags_next;
  logic [CFG_EN_WIDTH-1:0]      enable_reg, enable_next;
  logic                         capEnable_reg, capEnable_next;
  logic [GF_WIDTH-1:0]          gpFlags_reg, gpFlags_next;
  logic                         rtc_buffered_output_enable_reg, rtc_buffered_output_enable_next;
  logic                         wake_request_output_enable_reg, wake_request_output_enable_next;
  logic                         supply_monitor_disable_reg, supply_monitor_disable_next;
  logic [COUNT_WIDTH-1:0]       hold_reg, hold_next;
  logic [COUNT_WIDTH-1:0]       wakeLow_reg, wakeLow_next;
  logic [7:0]                   rdata_reg, rdata_next;
  logic                         porReq_reg, porReq_next;
  logic                         keepOn_reg, keepOn_next;

  // Address decode for the four registers.
  logic selPcon;
  logic selCfg;
  logic selFlag;
  logic selMode;
  always_comb begin
    selPcon = 1'b0;
    selCfg  = 1'b0;
    selFlag = 1'b0;
    selMode = 1'b0;
    if (sfrAddr == ADDR_POWER_CONTROL) begin
      selPcon = 1'b1;
    end else if (sfrAddr == ADDR_POWER_CONFIG_WAKE && sfrPage == PAGE_PMU) begin
      selCfg = 1'b1;
    end else if (sfrAddr == ADDR_WAKE_FLAG_EXTRA && sfrPage == PAGE_PMU) begin
      selFlag = 1'b1;
    end else if (sfrAddr == ADDR_MODE_OPTIONS && sfrPage == PAGE_MODE) begin
      selMode = 1'b1;
    end
  end

  // Effective enables; the reset pin always wakes, capacitive sense only
  // from suspend because that peripheral is unpowered in sleep.
  logic [WAKE_COUNT-1:0] wakeMask;
  logic                  cfgWr;
  logic                  clearReq;
  always_comb begin
    wakeMask                = {capEnable_reg, 1'b1, enable_reg};
    cfgWr                   = sfrWrite && selCfg;
    clearReq                = cfgWr && sfrWdata[CFG_CLEAR_BIT];
  end

  // Wake-up flags and enables; a new event wins over a clear.
  always_comb begin
    flags_next     = flags_reg;
    enable_next    = enable_reg;
    capEnable_next = capEnable_reg;
    if (clearReq) begin
      flags_next = FLAGS_RESET;
    end
    flags_next = flags_next | evtPulse;
    if (cfgWr) begin
      enable_next = sfrWdata[CFG_EN_WIDTH-1:0];
    end
    if (sfrWrite && selFlag) begin
      capEnable_next = sfrWdata[0];
    end
    keepOn_next = |flags_next;
  end

  // General purpose flags and mode options.
  always_comb begin
    gpFlags_next = gpFlags_reg;
    rtc_buffered_output_enable_next   = rtc_buffered_output_enable_reg;
    wake_request_output_enable_next  = wake_request_output_enable_reg;
    supply_monitor_disable_next  = supply_monitor_disable_reg;
    if (sfrWrite && selPcon) begin
      gpFlags_next = sfrWdata[POWER_CONTROL_GF_MSB:POWER_CONTROL_GF_LSB];
    end
    if (sfrWrite && selMode) begin
      rtc_buffered_output_enable_next  = sfrWdata[MODE_RTC_OE_BIT];
      wake_request_output_enable_next = sfrWdata[MODE_WAKE_OE_BIT];
      supply_monitor_disable_next = sfrWdata[MODE_SUPPLY_MONITOR_DISABLE_BIT];
    end
    porReq_next = supply_monitor_disable_reg && rstSrcLevel;
  end

  // Power state sequencer.
  always_comb begin
    state_next   = state_reg;
    hold_next    = (hold_reg != '0) ? hold_reg - 1'b1 : hold_reg;
    wakeLow_next = (wakeLow_reg != '0) ? wakeLow_reg - 1'b1 : wakeLow_reg;
    case (state_reg)
      ST_ACTIVE: begin
        if (cfgWr && sfrWdata[CFG_SLEEP_BIT] && !keepOn_reg) begin
          state_next = ST_SLEEP;
        end else if (cfgWr && sfrWdata[CFG_SUSPEND_BIT] && !keepOn_reg) begin
          state_next = ST_SUSPEND;
        end else if (sfrWrite && selPcon && sfrWdata[POWER_CONTROL_STOP_BIT]) begin
          state_next = ST_STOP;
        end else if (sfrWrite && selPcon && sfrWdata[POWER_CONTROL_IDLE_BIT]) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (interruptPending) begin
          state_next = ST_ACTIVE;
        end
      end
      ST_STOP: begin
        state_next = ST_STOP;
      end
      ST_SUSPEND: begin
        if (|(evtPulse & wakeMask)) begin
          state_next = ST_WAKE;
          hold_next  = COUNT_WIDTH'(FLAG_HOLD_CYCLES);
        end
      end
      ST_SLEEP: begin
        if (|(evtPulse & wakeMask & ~(WAKE_COUNT'(1) << FLAG_CAPSENSE))) begin
          state_next   = ST_ACTIVE;
          wakeLow_next = COUNT_WIDTH'(WAKE_LOW_CYCLES);
        end
      end
      ST_WAKE: begin
        if (hold_reg == COUNT_WIDTH'(1)) begin
          state_next = ST_ACTIVE;
        end
      end
      default: begin
        state_next = ST_ACTIVE;
      end
    endcase
  end

  // Read data: flags masked during the post-suspend window.
  logic [WAKE_COUNT-1:0] flagsVisible;
  always_comb begin
    flagsVisible = (hold_reg != '0) ? FLAGS_RESET : flags_reg;
    rdata_next   = rdata_reg;
    if (sfrRead) begin
      rdata_next = RESET_BYTE;
      if (selPcon) begin
        rdata_next[POWER_CONTROL_GF_MSB:POWER_CONTROL_GF_LSB] = gpFlags_reg;
      end else if (selCfg) begin
        rdata_next[CFG_RSTWAKE_BIT:0] = flagsVisible[FLAG_RSTPIN:0];
      end else if (selFlag) begin
        rdata_next[0] = flagsVisible[FLAG_CAPSENSE];
      end else if (selMode) begin
        rdata_next[MODE_RTC_OE_BIT]  = rtc_buffered_output_enable_reg;
        rdata_next[MODE_WAKE_OE_BIT] = wake_request_output_enable_reg;
        rdata_next[MODE_SUPPLY_MONITOR_DISABLE_BIT]  = supply_monitor_disable_reg;
      end
    end
  end

  // All register updates except the decoded power controls.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg     <= ST_ACTIVE;
      flags_reg     <= FLAGS_RESET;
      enable_reg    <= '0;
      capEnable_reg <= 1'b0;
      gpFlags_reg   <= '0;
      rtc_buffered_output_enable_reg     <= 1'b0;
      wake_request_output_enable_reg    <= 1'b0;
      supply_monitor_disable_reg    <= 1'b0;
      hold_reg      <= '0;
      wakeLow_reg   <= '0;
      rdata_reg     <= RESET_BYTE;
      porReq_reg    <= 1'b0;
      keepOn_reg    <= 1'b0;
    end else begin
      state_reg     <= state_next;
      flags_reg     <= flags_next;
      enable_reg    <= enable_next;
      capEnable_reg <= capEnable_next;
      gpFlags_reg   <= gpFlags_next;
      rtc_buffered_output_enable_reg     <= rtc_buffered_output_enable_next;
      wake_request_output_enable_reg    <= wake_request_output_enable_next;
      supply_monitor_disable_reg    <= supply_monitor_disable_next;
      hold_reg      <= hold_next;
      wakeLow_reg   <= wakeLow_next;
      rdata_reg     <= rdata_next;
      porReq_reg    <= porReq_next;
      keepOn_reg    <= keepOn_next;
    end
  end

  // Decoded power controls, registered so every output is a flop.
  logic cpuHalt_reg;
  logic precStop_reg;
  logic clkGate_reg;
  logic regOff_reg;
  logic wakeN_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cpuHalt_reg  <= 1'b0;
      precStop_reg <= 1'b0;
      clkGate_reg  <= 1'b0;
      regOff_reg   <= 1'b0;
      wakeN_reg    <= 1'b1;
    end else begin
      cpuHalt_reg  <= state_next != ST_ACTIVE;
      precStop_reg <= state_next == ST_STOP;
      clkGate_reg  <= state_next == ST_SUSPEND;
      regOff_reg   <= state_next == ST_SLEEP;
      wakeN_reg    <= !(wake_request_output_enable_next && wakeLow_next != '0);
    end
  end

  // Output wiring.
  assign sfrRdata             = rdata_reg;
  assign powerState           = state_reg;
  assign cpuHalt              = cpuHalt_reg;
  assign precisionOscStop     = precStop_reg;
  assign sysClockGate         = clkGate_reg;
  assign regulatorOff         = regOff_reg;
  assign lowPowerOscKeepOn    = keepOn_reg;
  assign rtcPinEnable         = rtc_buffered_output_enable_reg;
  assign wakePinEnable        = wake_request_output_enable_reg;
  assign wakeRequestN         = wakeN_reg;
  assign supplyMonitorDisable = supply_monitor_disable_reg;
  assign fullPorRequest       = porReq_reg;

endmodule

// [test/power_mode_wakeup_control_properties.sv]
/*
  Checker for the power mode and wake-up control block, bound to its top.
  Assumes one clock domain and the asynchronous active-high reset.
*/
`timescale 1ns/1ps
module power_mode_wakeup_control_properties (
  // Clock and reset.
  input wire logic                         clk,
  input wire logic                         reset,
  // Register port.
  input wire logic                         sfrWrite,
  input wire logic                         sfrRead,
  input wire logic [7:0]                   sfrAddr,
  input wire logic [3:0]                   sfrPage,
  input wire logic [7:0]                   sfrWdata,
  input wire logic [7:0]                   sfrRdata,
  // Requests and power outputs.
  input wire logic                         interruptPending,
  input wire power_mode_pkg::power_state_e powerState,
  input wire logic                         sysClockGate,
  input wire logic                         regulatorOff,
  input wire logic                         lowPowerOscKeepOn,
  input wire logic                         rtcPinEnable,
  input wire logic                         wakePinEnable,
  input wire logic                         wakeRequestN,
  input wire logic                         supplyMonitorDisable
);
  import power_mode_pkg::*;
  logic cfgWr;
  logic ctlWr;
  logic modeWr;
  // Decodes of the writes that change modes or options.
  assign cfgWr  = sfrWrite && sfrAddr == ADDR_POWER_CONFIG_WAKE && sfrPage == PAGE_PMU;
  assign ctlWr  = sfrWrite && sfrAddr == ADDR_POWER_CONTROL;
  assign modeWr = sfrWrite && sfrAddr == ADDR_MODE_OPTIONS && sfrPage == PAGE_MODE;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sleep_entry_a: assert property (
    cfgWr && sfrWdata[7] && powerState == ST_ACTIVE && !lowPowerOscKeepOn
    |=> powerState == ST_SLEEP && regulatorOff) else $error("Sleep write missed.");
  suspend_entry_a: assert property (
    cfgWr && sfrWdata[7:6] == 2'b01 && powerState == ST_ACTIVE && !lowPowerOscKeepOn
    |=> powerState == ST_SUSPEND) else $error("Suspend write missed.");
  flag_block_a: assert property (
    cfgWr && sfrWdata[7:6] != 2'b00 && powerState == ST_ACTIVE && lowPowerOscKeepOn
    |=> powerState == ST_ACTIVE) else $error("Blocked low power entry taken.");
  stop_entry_a: assert property (
    ctlWr && sfrWdata[1] && powerState == ST_ACTIVE |=> powerState == ST_STOP)
    else $error("Stop write missed.");
  idle_entry_a: assert property (
    ctlWr && sfrWdata[1:0] == 2'b01 && powerState == ST_ACTIVE && !interruptPending
    |=> powerState == ST_IDLE) else $error("Idle write missed.");
  stop_hold_a: assert property (
    powerState == ST_STOP |=> powerState == ST_STOP) else $error("Stop left without reset.");
  clock_gate_a: assert property (
    sysClockGate == (powerState == ST_SUSPEND)) else $error("Clock gate wrong.");
  wake_low_a: assert property (
    !$past(reset) && $past(powerState) == ST_SLEEP && powerState == ST_ACTIVE && wakePinEnable
    |-> !wakeRequestN [*8]) else $error("Wake request not low.");
  mode_opts_a: assert property (
    modeWr |=> {rtcPinEnable, wakePinEnable, supplyMonitorDisable} == $past(sfrWdata[7:5]))
    else $error("Mode option outputs wrong.");
  mode_read_a: assert property (
    sfrRead && sfrAddr == ADDR_MODE_OPTIONS && sfrPage == PAGE_MODE |=> sfrRdata[4:0] == 5'h00)
    else $error("Mode low bits not zero.");
  // Main scenarios reached.
  sleep_seen_c: cover property (powerState == ST_SLEEP ##1 powerState == ST_ACTIVE);
  wake_seen_c: cover property (powerState == ST_SUSPEND ##1 powerState == ST_WAKE);
  stop_seen_c: cover property (powerState == ST_STOP);
endmodule
bind power_mode_wakeup_control power_mode_wakeup_control_properties chk (
  .clk, .reset, .sfrWrite, .sfrRead, .sfrAddr, .sfrPage, .sfrWdata, .sfrRdata,
  .interruptPending, .powerState, .sysClockGate, .regulatorOff, .lowPowerOscKeepOn,
  .rtcPinEnable, .wakePinEnable, .wakeRequestN, .supplyMonitorDisable
);

// [test/power_mode_wakeup_control_bench.sv]
/*
  Self-checking bench for the power mode and wake-up control block.
  Assumes the 100 MHz clock and the register port timing of the hand-over.
*/
`timescale 1ns/1ps
module power_mode_wakeup_control_bench;
  import power_mode_pkg::*;
  typedef struct packed {
    logic [7:0] addr;
    logic [3:0] page;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } row_s;
  logic         clk, reset, sfrWrite, sfrRead, resetSourceActive, interruptPending;
  logic [7:0]   sfrAddr, sfrWdata, sfrRdata;
  logic [3:0]   sfrPage;
  logic [5:0]   ev;
  power_state_e powerState;
  logic         cpuHalt, precisionOscStop, sysClockGate, regulatorOff, lowPowerOscKeepOn;
  logic         rtcPinEnable, wakePinEnable, wakeRequestN, supplyMonitorDisable, fullPorRequest;
  int           numErrors, testsRun;
  row_s         rows [5];

  power_mode_wakeup_control dut (
    .clk(clk), .reset(reset), .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrAddr(sfrAddr),
    .sfrPage(sfrPage), .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .rtcOscFail(ev[3]),
    .rtcAlarm(ev[2]), .portMatch(ev[1]), .comparatorRise(ev[0]), .capSenseEvent(ev[5]),
    .resetPinGlitch(ev[4]), .resetSourceActive(resetSourceActive),
    .interruptPending(interruptPending), .powerState(powerState), .cpuHalt(cpuHalt),
    .precisionOscStop(precisionOscStop), .sysClockGate(sysClockGate),
    .regulatorOff(regulatorOff), .lowPowerOscKeepOn(lowPowerOscKeepOn),
    .rtcPinEnable(rtcPinEnable), .wakePinEnable(wakePinEnable), .wakeRequestN(wakeRequestN),
    .supplyMonitorDisable(supplyMonitorDisable), .fullPorRequest(fullPorRequest)
  );

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  // Compares one value and reports a difference at once.
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      numErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One register write, released on the same edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [3:0] p, input logic [7:0] d);
    @(posedge clk);
    sfrWrite <= 1'b1;
    sfrAddr  <= a;
    sfrPage  <= p;
    sfrWdata <= d;
    @(posedge clk);
    sfrWrite <= 1'b0;
    @(negedge clk);
  endtask

  // One register read, with the answer compared once it has settled.
  task automatic rd(input logic [7:0] a, input logic [3:0] p, input logic [7:0] exp);
    @(posedge clk);
    sfrRead <= 1'b1;
    sfrAddr <= a;
    sfrPage <= p;
    @(posedge clk);
    sfrRead <= 1'b0;
    @(negedge clk);
    chk("sfrRdata", sfrRdata, exp);
  endtask

  // Raises the chosen event lines long enough to pass the synchronisers.
  task automatic pulse(input logic [5:0] m);
    @(posedge clk);
    ev <= m;
    repeat (3) @(posedge clk);
    ev <= 6'h00;
    repeat (6) @(negedge clk);
  endtask

  // Waits a bounded time for a power state, then compares it.
  task automatic wait_state(input power_state_e s);
    int n;
    n = 0;
    while (powerState !== s && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("powerState", 8'(powerState), 8'(s));
  endtask

  // Holds reset for ten clocks.
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", testsRun, numErrors);
    if (numErrors == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    end_of_test();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    reset = 1'b1;
    {sfrWrite, sfrRead, resetSourceActive, interruptPending} = 4'h0;
    {sfrAddr, sfrWdata, sfrPage, ev} = '0;
    rows = '{'{ADDR_POWER_CONTROL, 4'h5, 8'hFC, 8'hFC},
             '{ADDR_MODE_OPTIONS, PAGE_MODE, 8'hFF, 8'hE0},
             '{ADDR_WAKE_FLAG_EXTRA, PAGE_PMU, 8'hFF, 8'h00},
             '{ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h1F, 8'h00},
             '{8'h90, PAGE_PMU, 8'hFF, 8'h00}};
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk("powerState", 8'(powerState), 8'(ST_ACTIVE));
    chk("wakeRequestN", 8'(wakeRequestN), 8'h01);
    rd(ADDR_POWER_CONTROL, PAGE_PMU, 8'h00);
    rd(ADDR_MODE_OPTIONS, PAGE_MODE, 8'h00);
    // Write and read back each register row.
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].addr, rows[i].page, rows[i].wdata);
      rd(rows[i].addr, rows[i].page, rows[i].rexp);
    end
    chk("modePins", 8'({rtcPinEnable, wakePinEnable, supplyMonitorDisable}), 8'h07);
    // Every event sets its flag; set flags block sleep until cleared.
    pulse(6'h3F);
    rd(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h1F);
    rd(ADDR_WAKE_FLAG_EXTRA, PAGE_PMU, 8'h01);
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h80);
    chk("powerState", 8'(powerState), 8'(ST_ACTIVE));
    chk("lowPowerOscKeepOn", 8'(lowPowerOscKeepOn), 8'h01);
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h20);
    rd(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h00);
    rd(ADDR_WAKE_FLAG_EXTRA, PAGE_PMU, 8'h00);
    chk("lowPowerOscKeepOn", 8'(lowPowerOscKeepOn), 8'h00);
    // Sleep with the alarm enabled in the same write, woken by the alarm.
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h84);
    chk("powerState", 8'(powerState), 8'(ST_SLEEP));
    chk("regulatorOff", 8'(regulatorOff), 8'h01);
    pulse(6'h04);
    wait_state(ST_ACTIVE);
    chk("wakeRequestN", 8'(wakeRequestN), 8'h00);
    rd(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h04);
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h20);
    // Suspend ignores a disabled source and wakes on the enabled one.
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h41);
    chk("sysClockGate", 8'(sysClockGate), 8'h01);
    pulse(6'h02);
    chk("powerState", 8'(powerState), 8'(ST_SUSPEND));
    // The comparator edge wakes; a read taken in the next two clocks sees no flags.
    @(posedge clk);
    ev <= 6'h01;
    repeat (2) @(posedge clk);
    rd(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h00);
    chk("powerState", 8'(powerState), 8'(ST_WAKE));
    @(posedge clk);
    ev <= 6'h00;
    wait_state(ST_ACTIVE);
    rd(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h03);
    wr(ADDR_POWER_CONFIG_WAKE, PAGE_PMU, 8'h20);
    // Stop holds until reset; flags keep their value meanwhile.
    wr(ADDR_POWER_CONTROL, PAGE_PMU, 8'hFE);
    chk("precisionOscStop", 8'(precisionOscStop), 8'h01);
    @(posedge clk);
    interruptPending <= 1'b1;
    repeat (3) @(negedge clk);
    chk("powerState", 8'(powerState), 8'(ST_STOP));
    rd(ADDR_POWER_CONTROL, PAGE_PMU, 8'hFC);
    @(posedge clk);
    interruptPending <= 1'b0;
    do_reset();
    chk("powerState", 8'(powerState), 8'(ST_ACTIVE));
    // Idle is left when an interrupt is pending.
    wr(ADDR_POWER_CONTROL, PAGE_PMU, 8'h01);
    chk("cpuHalt", 8'(cpuHalt), 8'h01);
    @(posedge clk);
    interruptPending <= 1'b1;
    repeat (2) @(negedge clk);
    chk("powerState", 8'(powerState), 8'(ST_ACTIVE));
    @(posedge clk);
    interruptPending <= 1'b0;
    // With the monitor off, a reset source asks for a full power-on reset.
    wr(ADDR_MODE_OPTIONS, PAGE_MODE, 8'h20);
    @(posedge clk);
    resetSourceActive <= 1'b1;
    repeat (4) @(negedge clk);
    chk("fullPorRequest", 8'(fullPorRequest), 8'h01);
    @(posedge clk);
    resetSourceActive <= 1'b0;
    end_of_test();
  end
endmodule
